//--- hw/gdpr_pkg.sv
package gdpr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_P9_DIR = 8'hD0;
  localparam logic [7:0] IDX_PA_DIR = 8'hD1;
  localparam logic [7:0] IDX_P9_DATA = 8'hD2;
  localparam logic [7:0] IDX_PA_DATA = 8'hD3;
  localparam logic [7:0] IDX_PB_DIR = 8'hD4;
  localparam logic [7:0] IDX_PB_DATA = 8'hD6;
  localparam logic [7:0] IDX_P2_PULLUP = 8'hD8;
  localparam logic [7:0] IDX_P4_PULLUP = 8'hD9;
  localparam logic [7:0] IDX_P5_PULLUP = 8'hDA;
  localparam int ADDR_WIDTH = 10;
  localparam int P9_PINS = 6;
  localparam int P5_PINS = 4;
  localparam int PORT_PINS = 8;
  localparam int MODE_WIDTH = 3;
  // Reset values
  localparam logic [5:0] P9_RESET = 6'h00;
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [3:0] P5_RESET = 4'h0;
  // Fixed read values of unused bits and write-only registers
  localparam logic [1:0] P9_UNUSED_READ = 2'h3;
  localparam logic [3:0] P5_UNUSED_READ = 4'hF;
  localparam logic [7:0] WO_READ = 8'hFF;
  // Modes in which port A bit 7 is held as output
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam int PA_FIXED_BIT = 7;
  // Cycles after reset release before the mode strap is taken
  localparam logic [1:0] STRAP_DELAY = 2'h2;
endpackage : gdpr_pkg

//--- hw/gdpr_sync.sv
`timescale 1ns/1ps
module gdpr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [WIDTH-1:0] d, // Asynchronous input
  output logic [WIDTH-1:0] q // Synchronised output
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule : gdpr_sync

//--- hw/gdpr_top.sv
`timescale 1ns/1ps
// Functional notes
// - Direction 0 input, 1 output from data
// - Port 9 direction covers pins 5..0 only
// - Port 9 data bits 5..0, 7..6 read 1
// - Pull-up on when set, only for inputs
// - Port 2 pull-ups: eight RW bits, reset 0
module gdpr_top (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rst_n, // Async reset, active low
  input wire logic hsel, // AHB slave select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response, always OKAY
  input wire logic [2:0] mode_pins, // Operating mode strap
  input wire logic [5:0] port9_pin_in, // Port 9 pin levels
  output logic [5:0] port9_pin_out, // Port 9 pin drive value
  output logic [5:0] port9_pin_oe, // Port 9 pin drive enable
  input wire logic [7:0] porta_pin_in, // Port A pin levels
  output logic [7:0] porta_pin_out, // Port A pin drive value
  output logic [7:0] porta_pin_oe, // Port A pin drive enable
  input wire logic [7:0] portb_pin_in, // Port B pin levels
  output logic [7:0] portb_pin_out, // Port B pin drive value
  output logic [7:0] portb_pin_oe, // Port B pin drive enable
  input wire logic [7:0] port2_direction, // Port 2 direction bits
  input wire logic [7:0] port4_direction, // Port 4 direction bits
  input wire logic [3:0] port5_direction, // Port 5 direction bits
  output logic [7:0] port2_pullup_on, // Port 2 pull-up transistor on
  output logic [7:0] port4_pullup_on, // Port 4 pull-up transistor on
  output logic [3:0] port5_pullup_on // Port 5 pull-up transistor on
);
  localparam int SYNC_W = 6 + 8 + 8 + 3;

  logic [SYNC_W-1:0] sync_q;
  logic [5:0] p9_in_s;
  logic [7:0] pa_in_s;
  logic [7:0] pb_in_s;
  logic [2:0] mode_s;

  gdpr_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({mode_pins, portb_pin_in, porta_pin_in, port9_pin_in}),
    .q(sync_q)
  );

  assign p9_in_s = sync_q[5:0];
  assign pa_in_s = sync_q[13:6];
  assign pb_in_s = sync_q[21:14];
  assign mode_s = sync_q[24:22];

  function automatic logic [7:0] idx_of(input logic [31:0] a);
    // Upper address bits must be zero for a hit
    idx_of = (a[31:gdpr_pkg::ADDR_WIDTH] == '0) ? a[9:2] : 8'h00;
  endfunction : idx_of

  // Input pins read their level, output pins the latched data
  function automatic logic [7:0] pin_view(input logic [7:0] dir, input logic [7:0] dat,
                                          input logic [7:0] pin);
    pin_view = (dir & dat) | (~dir & pin);
  endfunction : pin_view

  logic [5:0] p9_dir_reg, p9_dir_next;
  logic [5:0] p9_data_reg, p9_data_next;
  logic [7:0] pa_dir_reg, pa_dir_next;
  logic [7:0] pa_data_reg, pa_data_next;
  logic [7:0] pb_dir_reg, pb_dir_next;
  logic [7:0] pb_data_reg, pb_data_next;
  logic [7:0] p2_pu_reg, p2_pu_next;
  logic [7:0] p4_pu_reg, p4_pu_next;
  logic [3:0] p5_pu_reg, p5_pu_next;
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] idx_reg, idx_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic mode_fixed_reg, mode_fixed_next;
  logic strap_done_reg, strap_done_next;
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic [7:0] p2_on_reg, p2_on_next;
  logic [7:0] p4_on_reg, p4_on_next;
  logic [3:0] p5_on_reg, p5_on_next;
  logic take;
  logic [7:0] wd;
  logic [7:0] rd;
  logic fixed_now;

  assign take = hsel && htrans[1] && hready;
  assign wd = hwdata[7:0];

  always_comb begin
    p9_dir_next = p9_dir_reg;
    p9_data_next = p9_data_reg;
    pa_dir_next = pa_dir_reg;
    pa_data_next = pa_data_reg;
    pb_dir_next = pb_dir_reg;
    pb_data_next = pb_data_reg;
    p2_pu_next = p2_pu_reg;
    p4_pu_next = p4_pu_reg;
    p5_pu_next = p5_pu_reg;
    strap_cnt_next = strap_cnt_reg;
    strap_done_next = strap_done_reg;
    mode_fixed_next = mode_fixed_reg;
    fixed_now = 1'b0;
    // Strap is sampled once, after the synchroniser has settled
    if (!strap_done_reg) begin
      if (strap_cnt_reg == gdpr_pkg::STRAP_DELAY) begin
        strap_done_next = 1'b1;
        fixed_now = (mode_s == gdpr_pkg::MODE_3) || (mode_s == gdpr_pkg::MODE_4) ||
                    (mode_s == gdpr_pkg::MODE_6);
        mode_fixed_next = fixed_now;
      end else begin
        strap_cnt_next = strap_cnt_reg + 2'h1;
      end
    end
    if (wr_pend_reg) begin
      unique case (idx_reg)
        gdpr_pkg::IDX_P9_DIR: p9_dir_next = wd[5:0];
        gdpr_pkg::IDX_PA_DIR: pa_dir_next = wd;
        gdpr_pkg::IDX_P9_DATA: p9_data_next = wd[5:0];
        gdpr_pkg::IDX_PA_DATA: pa_data_next = wd;
        gdpr_pkg::IDX_PB_DIR: pb_dir_next = wd;
        gdpr_pkg::IDX_PB_DATA: pb_data_next = wd;
        gdpr_pkg::IDX_P2_PULLUP: p2_pu_next = wd;
        gdpr_pkg::IDX_P4_PULLUP: p4_pu_next = wd;
        gdpr_pkg::IDX_P5_PULLUP: p5_pu_next = wd[3:0];
        default: ;
      endcase
    end
    if (mode_fixed_next) begin
      pa_dir_next[gdpr_pkg::PA_FIXED_BIT] = 1'b1;
    end
  end

  // Read mux works on next values so a write just before a read is seen
  always_comb begin
    rd = 8'h00;
    unique case (idx_of(haddr))
      gdpr_pkg::IDX_P9_DIR, gdpr_pkg::IDX_PA_DIR, gdpr_pkg::IDX_PB_DIR: rd = gdpr_pkg::WO_READ;
      gdpr_pkg::IDX_P9_DATA: begin
        rd = pin_view({2'h0, p9_dir_next}, {2'h0, p9_data_next}, {2'h0, p9_in_s});
        rd[7:6] = gdpr_pkg::P9_UNUSED_READ;
      end
      gdpr_pkg::IDX_PA_DATA: rd = pin_view(pa_dir_next, pa_data_next, pa_in_s);
      gdpr_pkg::IDX_PB_DATA: rd = pin_view(pb_dir_next, pb_data_next, pb_in_s);
      gdpr_pkg::IDX_P2_PULLUP: rd = p2_pu_next;
      gdpr_pkg::IDX_P4_PULLUP: rd = p4_pu_next;
      gdpr_pkg::IDX_P5_PULLUP: rd = {gdpr_pkg::P5_UNUSED_READ, p5_pu_next};
      default: rd = 8'h00;
    endcase
  end

  always_comb begin
    wr_pend_next = take && hwrite;
    idx_next = take ? idx_of(haddr) : idx_reg;
    hrdata_next = (take && !hwrite) ? {24'h000000, rd} : 32'h00000000;
    // Pull-up only where the pin is an input
    p2_on_next = p2_pu_reg & ~port2_direction;
    p4_on_next = p4_pu_reg & ~port4_direction;
    p5_on_next = p5_pu_reg & ~port5_direction;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p9_dir_reg <= gdpr_pkg::P9_RESET;
      p9_data_reg <= gdpr_pkg::P9_RESET;
      pa_dir_reg <= gdpr_pkg::PORT_RESET;
      pa_data_reg <= gdpr_pkg::PORT_RESET;
      pb_dir_reg <= gdpr_pkg::PORT_RESET;
      pb_data_reg <= gdpr_pkg::PORT_RESET;
      p2_pu_reg <= gdpr_pkg::PORT_RESET;
      p4_pu_reg <= gdpr_pkg::PORT_RESET;
      p5_pu_reg <= gdpr_pkg::P5_RESET;
      wr_pend_reg <= 1'b0;
      idx_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
      mode_fixed_reg <= 1'b0;
      strap_done_reg <= 1'b0;
      strap_cnt_reg <= 2'h0;
      p2_on_reg <= 8'h00;
      p4_on_reg <= 8'h00;
      p5_on_reg <= 4'h0;
    end else begin
      p9_dir_reg <= p9_dir_next;
      p9_data_reg <= p9_data_next;
      pa_dir_reg <= pa_dir_next;
      pa_data_reg <= pa_data_next;
      pb_dir_reg <= pb_dir_next;
      pb_data_reg <= pb_data_next;
      p2_pu_reg <= p2_pu_next;
      p4_pu_reg <= p4_pu_next;
      p5_pu_reg <= p5_pu_next;
      wr_pend_reg <= wr_pend_next;
      idx_reg <= idx_next;
      hrdata_reg <= hrdata_next;
      mode_fixed_reg <= mode_fixed_next;
      strap_done_reg <= strap_done_next;
      strap_cnt_reg <= strap_cnt_next;
      p2_on_reg <= p2_on_next;
      p4_on_reg <= p4_on_next;
      p5_on_reg <= p5_on_next;
    end
  end

  // Zero-wait slave: every transfer completes in one data-phase cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign port9_pin_oe = p9_dir_reg;
  assign port9_pin_out = p9_data_reg;
  assign porta_pin_oe = pa_dir_reg;
  assign porta_pin_out = pa_data_reg;
  assign portb_pin_oe = pb_dir_reg;
  assign portb_pin_out = pb_data_reg;
  assign port2_pullup_on = p2_on_reg;
  assign port4_pullup_on = p4_on_reg;
  assign port5_pullup_on = p5_on_reg;

  a_dir_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pend_reg && idx_reg == gdpr_pkg::IDX_PB_DIR |=> portb_pin_oe == $past(hwdata[7:0]))
    else $error("port B direction write not applied");
  a_p9_dir_width: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pend_reg && idx_reg == gdpr_pkg::IDX_P9_DIR |=> port9_pin_oe == $past(hwdata[5:0]))
    else $error("port 9 direction write wrong");
  a_p9_read_ones: assert property (@(posedge clk) disable iff (!rst_n)
    take && !hwrite && idx_of(haddr) == gdpr_pkg::IDX_P9_DATA |=> hrdata[7:6] == 2'h3)
    else $error("port 9 unused bits not read as one");
  a_pullup_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 port4_pullup_on == ($past(p4_pu_reg) & ~$past(port4_direction)))
    else $error("port 4 pull-up not gated by direction");
  a_p2_pullup_rw: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pend_reg && idx_reg == gdpr_pkg::IDX_P2_PULLUP ##1 !port2_direction[0] && !wr_pend_reg
    |=> port2_pullup_on[0] == $past(hwdata[0], 2))
    else $error("port 2 pull-up write not effective");
  a_pa7_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    mode_fixed_reg |-> porta_pin_oe[7] ##1 mode_fixed_reg)
    else $error("port A bit 7 not held as output");
endmodule : gdpr_top

//--- testbench/gdpr_pin_model.sv
`timescale 1ns/1ps
// Outside circuitry: a driven pin shows its drive, an input pin the outside level
module gdpr_pin_model #(
  parameter int W = 8
) (
  input wire logic [W-1:0] pin_out, // Port drive value
  input wire logic [W-1:0] pin_oe, // Port drives pin
  input wire logic [W-1:0] ext_level, // Outside source level
  output logic [W-1:0] pin_in // Resolved pin level
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gdpr_pin_model

//--- testbench/test_gpio_direction_pullup_regs.sv
`timescale 1ns/1ps
module test_gpio_direction_pullup_regs;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, fix;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, mode_pins;
  logic [5:0] p9_out, p9_oe, p9_in, e9;
  logic [7:0] pa_out, pa_oe, pa_in, pb_out, pb_oe, pb_in, ea, eb;
  logic [7:0] p2_dir, p4_dir, p2_pu, p4_pu;
  logic [3:0] p5_dir, p5_pu;
  logic [7:0] rg [16];
  int failures, tests_run;

  gdpr_top u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mode_pins(mode_pins), .port9_pin_in(p9_in),
    .port9_pin_out(p9_out), .port9_pin_oe(p9_oe), .porta_pin_in(pa_in),
    .porta_pin_out(pa_out), .porta_pin_oe(pa_oe), .portb_pin_in(pb_in),
    .portb_pin_out(pb_out), .portb_pin_oe(pb_oe), .port2_direction(p2_dir),
    .port4_direction(p4_dir), .port5_direction(p5_dir), .port2_pullup_on(p2_pu),
    .port4_pullup_on(p4_pu), .port5_pullup_on(p5_pu));
  gdpr_pin_model #(.W(6)) u_p9 (.pin_out(p9_out), .pin_oe(p9_oe), .ext_level(e9), .pin_in(p9_in));
  gdpr_pin_model #(.W(8)) u_pa (.pin_out(pa_out), .pin_oe(pa_oe), .ext_level(ea), .pin_in(pa_in));
  gdpr_pin_model #(.W(8)) u_pb (.pin_out(pb_out), .pin_oe(pb_oe), .ext_level(eb), .pin_in(pb_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task conclude;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Sampled at the falling edge so the value equals what the next rising edge sees
  task wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      failures++;
      $display("mismatch at %0t: bus hang", $time);
      conclude();
    end
    d = hrdata;
    chk(32'(hresp), 32'h0);
    @(posedge clk);
  endtask : wait_rdy

  task bus(input logic w, input logic [7:0] i, input logic [31:0] wd, output logic [31:0] d);
    logic [31:0] x;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= {22'h0, i, 2'h0};
    wait_rdy(x);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(d);
  endtask : bus

  task wr(input logic [7:0] i, input logic [7:0] v);
    logic [31:0] x;
    bus(1'b1, i, {24'h0, v}, x);
    rg[i[3:0]] = v;
  endtask : wr

  task rdc(input logic [7:0] i, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, i, 32'h0, x);
    chk(x, exp);
  endtask : rdc

  function automatic logic [7:0] mix(input logic [7:0] d, input logic [7:0] q, input logic [7:0] e);
    return (d & q) | (~d & e);
  endfunction : mix

  task verify;
    logic [7:0] pa, x;
    pa = rg[1] | (fix ? 8'h80 : 8'h00);
    x = mix(rg[0], rg[2], {2'h0, e9});
    chk(32'(p9_oe), 32'(rg[0][5:0]));
    chk(32'(p9_out), 32'(rg[2][5:0]));
    chk(32'(pa_oe), 32'(pa));
    chk(32'(pa_out), 32'(rg[3]));
    chk(32'(pb_oe), 32'(rg[4]));
    chk(32'(pb_out), 32'(rg[6]));
    chk(32'(p2_pu), 32'(rg[8] & ~p2_dir));
    chk(32'(p4_pu), 32'(rg[9] & ~p4_dir));
    chk(32'(p5_pu), 32'(rg[10][3:0] & ~p5_dir));
    rdc(gdpr_pkg::IDX_P9_DATA, {24'h0, gdpr_pkg::P9_UNUSED_READ, x[5:0]});
    rdc(gdpr_pkg::IDX_PA_DATA, {24'h0, mix(pa, rg[3], ea)});
    rdc(gdpr_pkg::IDX_PB_DATA, {24'h0, mix(rg[4], rg[6], eb)});
    rdc(gdpr_pkg::IDX_P2_PULLUP, {24'h0, rg[8]});
    rdc(gdpr_pkg::IDX_P4_PULLUP, {24'h0, rg[9]});
    rdc(gdpr_pkg::IDX_P5_PULLUP, {24'h0, gdpr_pkg::P5_UNUSED_READ, rg[10][3:0]});
    rdc(gdpr_pkg::IDX_P9_DIR, {24'h0, gdpr_pkg::WO_READ});
    rdc(gdpr_pkg::IDX_PA_DIR, {24'h0, gdpr_pkg::WO_READ});
    rdc(gdpr_pkg::IDX_PB_DIR, {24'h0, gdpr_pkg::WO_READ});
    rdc(8'hD5, 32'h0);
    rdc(8'hD7, 32'h0);
  endtask : verify

  initial begin
    rst_n = 1'b0;
    {hsel, hwrite, haddr, htrans, hwdata, mode_pins, fix} = '0;
    hsize = 3'h2;
    {e9, ea, eb, p2_dir, p4_dir, p5_dir} = '0;
    failures = 0;
    tests_run = 0;
    void'($urandom(25511));
    for (int m = 0; m < 8; m++) begin
      mode_pins <= 3'(m);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      fix = (m == 3) || (m == 4) || (m == 6);
      foreach (rg[k]) rg[k] = 8'h00;
      verify();
      for (int r = 0; r < 4; r++) begin
        p2_dir <= 8'($urandom);
        p4_dir <= 8'($urandom);
        p5_dir <= 4'($urandom);
        e9 <= 6'($urandom);
        ea <= 8'($urandom);
        eb <= 8'($urandom);
        // First round all ones: widest masks, then random values in later rounds
        for (int k = 0; k < 11; k++) wr(8'hD0 + 8'(k), (r == 0) ? 8'hFF : 8'($urandom));
        repeat (4) @(posedge clk);
        verify();
      end
    end
    conclude();
  end
endmodule : test_gpio_direction_pullup_regs
